// file: hw/mac_auto_pkg.sv
// Constants and types shared by the MAC automation block
package mac_auto_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // Delay and measurement time unit
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_W = 7;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
    localparam logic [2:0] FRAME_TYPE_DATA = 3'h1;
    localparam logic [2:0] FRAME_TYPE_CMD = 3'h3;
    localparam logic [1:0] ED_MODE_SINGLE = 2'h1;
    localparam logic [10:0] ACK_LEN_FCS16 = 11'h005;
    localparam logic [10:0] ACK_LEN_FCS32 = 11'h007;
    localparam logic [15:0] WAIT_RESET = 16'h0000;
    localparam logic BASEBAND_RESET = 1'b1;
    localparam logic CHECKSUM_32 = 1'b0;

    typedef enum logic [1:0] {
        PHY_FSK = 2'h0,
        PHY_OFDM = 2'h1,
        PHY_OQPSK = 2'h2
    } phy_mode_t;

    typedef enum logic [2:0] {
        ST_RX = 3'b000,
        ST_ED = 3'b001,
        ST_TRANSMIT_PREPARATION_STATE = 3'b011,
        ST_TX = 3'b010,
        ST_ACKWAIT = 3'b110
    } radio_state_t;
endpackage : mac_auto_pkg

// file: hw/mac_auto_procedures.sv
// Automatic acknowledgement, transmit-then-receive and CCA-with-transmit sequencer
`timescale 1ns/1ns
module mac_auto_procedures
    import mac_auto_pkg::*;
(
    input wire logic core_clk, // Baseband clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic auto_acknowledge_enable, // Auto ACK enable
    input wire logic ack_rate_adapt_enable, // ACK rate adaptation
    input wire logic ack_checksum_adapt_enable, // ACK checksum adaptation
    input wire logic ack_source_select, // 1: ACK from transmit buffer
    input wire logic transmit_then_receive_enable, // Return to receive after transmit
    input wire logic cca_transmit_enable, // CCA with transmit enable
    input wire logic [3:0] filter_unit_enable, // Address filter unit enables
    input wire logic [7:0] ack_delay_low, // ACK delay low byte, ticks
    input wire logic [7:0] ack_delay_high, // ACK delay high byte, ticks
    input wire logic [3:0] ack_pending_flags, // Pending flag per filter unit
    input wire logic [7:0] tx_length_low, // Transmit length low byte
    input wire logic [2:0] tx_length_high, // Transmit length high bits
    input wire logic [7:0] energy_threshold, // Busy threshold
    input wire logic [7:0] energy_detect_duration, // Measurement time, ticks
    input wire logic [1:0] phy_mode, // Active PHY, phy_mode_t
    input wire logic checksum_type_select, // Host checksum type, 0: 32-bit
    input wire logic [2:0] ofdm_cfg_coding_level, // Host OFDM coding level
    input wire logic fsk_cfg_delimiter_select, // Host FSK delimiter
    input wire logic oqpsk_cfg_legacy, // Host O-QPSK legacy flag
    input wire logic [2:0] oqpsk_cfg_rate_mode, // Host O-QPSK rate mode
    input wire logic oqpsk_cfg_ppdu_type, // Host O-QPSK PPDU type
    input wire logic baseband_enable_write, // Host write strobe for baseband enable
    input wire logic baseband_enable_wdata, // Value written
    input wire logic energy_detect_mode_write, // Host write strobe for energy mode
    input wire logic [1:0] energy_detect_mode, // Value written
    input wire logic host_tx_request, // Host transmit command
    input wire logic host_rx_request, // Host receive command
    input wire logic receive_frame_end, // Filtered frame end pulse
    input wire logic [2:0] rx_frame_type, // Received frame type
    input wire logic rx_ack_request, // Received ACK request bit
    input wire logic [3:0] rx_unit_match, // Matching filter units
    input wire logic [7:0] rx_sequence_number, // Received sequence number
    input wire logic rx_checksum_type, // Received checksum type, 0: 32-bit
    input wire logic [2:0] ofdm_rx_coding_level, // Received OFDM coding level
    input wire logic fsk_rx_delimiter_seen, // Received FSK delimiter
    input wire logic oqpsk_rx_legacy, // Received legacy flag
    input wire logic [2:0] oqpsk_rx_rate_mode, // Received rate mode
    input wire logic oqpsk_rx_ppdu_type, // Received PPDU type
    input wire logic [7:0] energy_level, // Energy measurement value
    input wire logic tx_done, // Transmitter finished pulse
    output radio_state_t radio_state, // Current radio state
    output logic tx_start, // Transmit start pulse
    output logic tx_from_buffer, // Transmit uses frame buffer
    output logic [10:0] tx_length, // Frame length in octets
    output logic [7:0] ack_sequence_number, // Internal ACK sequence number
    output logic ack_frame_pending, // ACK frame pending bit
    output logic checksum_type, // Effective checksum type
    output logic [2:0] ofdm_tx_coding_level, // Effective OFDM coding level
    output logic fsk_tx_delimiter_select, // Effective FSK delimiter
    output logic oqpsk_tx_legacy, // Effective legacy flag
    output logic [2:0] oqpsk_tx_rate_mode, // Effective rate mode
    output logic oqpsk_tx_ppdu_type, // Effective PPDU type
    output logic ed_active, // Energy measurement running
    output logic cca_busy_result, // Last CCA busy flag
    output logic baseband_enable, // Baseband enable bit
    output logic irq_energy_detect_complete, // Energy detect complete pulse
    output logic irq_transmit_frame_end, // Transmit frame end pulse
    output logic irq_transceiver_ready // Transceiver ready pulse
);

    radio_state_t state_r;
    logic [TICK_W-1:0] tick_r;
    logic [15:0] wait_r;
    logic ack_active_r;
    logic cca_go_r;
    logic busy_r;
    logic tx_start_r;
    logic irq_edc_r;
    logic irq_tfe_r;
    logic irq_rdy_r;
    logic bb_en_r;
    logic [7:0] seq_r;
    logic pend_r;
    logic rx_fcs_r;
    logic [2:0] ofdm_r;
    logic fsk_r;
    logic leg_r;
    logic [2:0] mod_r;
    logic ppdu_r;
    logic [10:0] len_r;
    logic fcs_r;
    logic [2:0] ofdm_out_r;
    logic fsk_out_r;
    logic leg_out_r;
    logic [2:0] mod_out_r;
    logic ppdu_out_r;

    logic aack_ok;
    logic ack_needed;
    logic pend_sel;
    logic wait_done;
    logic ed_start;
    logic ed_busy;
    logic adapt;
    logic fcs_adapt;

    assign aack_ok = auto_acknowledge_enable && (|filter_unit_enable);
    assign ack_needed = (rx_frame_type == FRAME_TYPE_DATA || rx_frame_type == FRAME_TYPE_CMD)
        && rx_ack_request;
    assign pend_sel = rx_unit_match[0] ? ack_pending_flags[0] :
                      rx_unit_match[1] ? ack_pending_flags[1] :
                      rx_unit_match[2] ? ack_pending_flags[2] :
                      rx_unit_match[3] ? ack_pending_flags[3] : 1'b0;
    assign wait_done = (wait_r == WAIT_RESET) && (tick_r == TICK_LAST);
    assign ed_start = state_r == ST_RX && cca_transmit_enable && energy_detect_mode_write
        && energy_detect_mode == ED_MODE_SINGLE;
    assign ed_busy = energy_level > energy_threshold;
    assign adapt = ack_active_r && ack_rate_adapt_enable;
    assign fcs_adapt = ack_active_r && ack_checksum_adapt_enable
        && (phy_mode == PHY_FSK || (phy_mode == PHY_OQPSK && leg_r));

    // Sequencer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_RX;
            ack_active_r <= 1'b0;
            cca_go_r <= 1'b0;
            tx_start_r <= 1'b0;
        end else begin
            tx_start_r <= 1'b0;
            case (state_r)
                ST_RX: begin
                    if (receive_frame_end && aack_ok) begin
                        if (ack_needed) begin
                            state_r <= ST_ACKWAIT;
                            ack_active_r <= 1'b1;
                        end else begin
                            state_r <= ST_TRANSMIT_PREPARATION_STATE;
                        end
                    end else if (ed_start) begin
                        state_r <= ST_ED;
                    end else if (host_tx_request) begin
                        state_r <= ST_TX;
                        tx_start_r <= 1'b1;
                    end
                end
                ST_ACKWAIT: begin
                    if (wait_done) begin
                        state_r <= ST_TX;
                        tx_start_r <= 1'b1;
                    end
                end
                ST_ED: begin
                    if (wait_done) begin
                        if (ed_busy) begin
                            state_r <= ST_RX;
                        end else begin
                            state_r <= ST_TRANSMIT_PREPARATION_STATE;
                            cca_go_r <= 1'b1;
                        end
                    end
                end
                ST_TRANSMIT_PREPARATION_STATE: begin
                    if (cca_go_r || host_tx_request) begin
                        state_r <= ST_TX;
                        tx_start_r <= 1'b1;
                        cca_go_r <= 1'b0;
                    end else if (host_rx_request) begin
                        state_r <= ST_RX;
                    end
                end
                ST_TX: begin
                    if (tx_done) begin
                        state_r <= transmit_then_receive_enable ? ST_RX : ST_TRANSMIT_PREPARATION_STATE;
                        ack_active_r <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_RX;
                end
            endcase
        end
    end

    // Tick prescaler and delay / duration counter
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tick_r <= '0;
            wait_r <= WAIT_RESET;
        end else if (state_r == ST_RX) begin
            tick_r <= '0;
            if (receive_frame_end && aack_ok) begin
                wait_r <= {ack_delay_high, ack_delay_low};
            end else begin
                wait_r <= {8'h00, energy_detect_duration};
            end
        end else if (state_r == ST_ACKWAIT || state_r == ST_ED) begin
            if (tick_r == TICK_LAST) begin
                tick_r <= '0;
                if (wait_r != WAIT_RESET) begin
                    wait_r <= wait_r - 16'h0001;
                end
            end else begin
                tick_r <= tick_r + TICK_W'(1);
            end
        end
    end

    // Capture of the received frame's properties
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            seq_r <= 8'h00;
            pend_r <= 1'b0;
            rx_fcs_r <= CHECKSUM_32;
            ofdm_r <= 3'h0;
            fsk_r <= 1'b0;
            leg_r <= 1'b0;
            mod_r <= 3'h0;
            ppdu_r <= 1'b0;
        end else if (state_r == ST_RX && receive_frame_end) begin
            seq_r <= rx_sequence_number;
            pend_r <= pend_sel;
            rx_fcs_r <= rx_checksum_type;
            ofdm_r <= ofdm_rx_coding_level;
            fsk_r <= fsk_rx_delimiter_seen;
            leg_r <= oqpsk_rx_legacy;
            mod_r <= oqpsk_rx_rate_mode;
            ppdu_r <= oqpsk_rx_ppdu_type;
        end
    end

    // Effective transmit settings; host values return once the ACK is out
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fcs_r <= CHECKSUM_32;
            ofdm_out_r <= 3'h0;
            fsk_out_r <= 1'b0;
            leg_out_r <= 1'b0;
            mod_out_r <= 3'h0;
            ppdu_out_r <= 1'b0;
            len_r <= 11'h000;
        end else begin
            fcs_r <= fcs_adapt ? rx_fcs_r : checksum_type_select;
            ofdm_out_r <= (adapt && phy_mode == PHY_OFDM) ? ofdm_r : ofdm_cfg_coding_level;
            fsk_out_r <= (adapt && phy_mode == PHY_FSK) ? fsk_r : fsk_cfg_delimiter_select;
            leg_out_r <= (adapt && phy_mode == PHY_OQPSK) ? leg_r : oqpsk_cfg_legacy;
            mod_out_r <= (adapt && phy_mode == PHY_OQPSK) ? mod_r : oqpsk_cfg_rate_mode;
            ppdu_out_r <= (adapt && phy_mode == PHY_OQPSK) ? ppdu_r : oqpsk_cfg_ppdu_type;
            if (ack_active_r && !ack_source_select) begin
                len_r <= (fcs_adapt ? rx_fcs_r : checksum_type_select) == CHECKSUM_32
                    ? ACK_LEN_FCS32 : ACK_LEN_FCS16;
            end else begin
                len_r <= {tx_length_high, tx_length_low};
            end
        end
    end

    // Interrupt pulses and CCA result
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            irq_edc_r <= 1'b0;
            irq_tfe_r <= 1'b0;
            irq_rdy_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            irq_edc_r <= state_r == ST_ED && wait_done;
            irq_tfe_r <= (state_r == ST_TX && tx_done)
                || (state_r == ST_ED && wait_done && ed_busy);
            irq_rdy_r <= state_r == ST_ED && wait_done && !ed_busy;
            if (state_r == ST_ED && wait_done) begin
                busy_r <= ed_busy;
            end
        end
    end

    // Baseband enable: hardware set on a clear channel wins over a host write
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bb_en_r <= BASEBAND_RESET;
        end else if (state_r == ST_ED && wait_done && !ed_busy) begin
            bb_en_r <= 1'b1;
        end else if (baseband_enable_write) begin
            bb_en_r <= baseband_enable_wdata;
        end
    end

    assign radio_state = state_r;
    assign tx_start = tx_start_r;
    assign tx_from_buffer = !ack_active_r || ack_source_select;
    assign tx_length = len_r;
    assign ack_sequence_number = seq_r;
    assign ack_frame_pending = pend_r;
    assign checksum_type = fcs_r;
    assign ofdm_tx_coding_level = ofdm_out_r;
    assign fsk_tx_delimiter_select = fsk_out_r;
    assign oqpsk_tx_legacy = leg_out_r;
    assign oqpsk_tx_rate_mode = mod_out_r;
    assign oqpsk_tx_ppdu_type = ppdu_out_r;
    assign ed_active = state_r == ST_ED;
    assign cca_busy_result = busy_r;
    assign baseband_enable = bb_en_r;
    assign irq_energy_detect_complete = irq_edc_r;
    assign irq_transmit_frame_end = irq_tfe_r;
    assign irq_transceiver_ready = irq_rdy_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    aack_gate_a: assert property (state_r == ST_RX && receive_frame_end && !aack_ok && !ed_start
        && !host_tx_request |=> state_r == ST_RX) else $error("ACK procedure ran while disabled");
    no_ack_end_a: assert property (state_r == ST_RX && receive_frame_end && aack_ok && !ack_needed
        |=> state_r == ST_TRANSMIT_PREPARATION_STATE && !tx_start_r) else $error("Unacknowledged frame not parked");
    ack_wait_a: assert property (state_r == ST_RX && receive_frame_end && aack_ok && ack_needed
        |=> state_r == ST_ACKWAIT && wait_r == $past({ack_delay_high, ack_delay_low}))
        else $error("ACK delay not loaded");
    ack_start_a: assert property (tx_start_r && ack_active_r |-> $past(state_r) == ST_ACKWAIT
        && $past(wait_done)) else $error("ACK started before delay elapsed");
    ack_len_a: assert property (ack_active_r && !ack_source_select && state_r == ST_TX
        ##1 ack_active_r |-> tx_length == ACK_LEN_FCS16 || tx_length == ACK_LEN_FCS32)
        else $error("Internal ACK length wrong");
    ofdm_adapt_a: assert property (adapt && phy_mode == PHY_OFDM && $stable(ofdm_r)
        |=> ofdm_tx_coding_level == $past(ofdm_r)) else $error("ACK coding level not adapted");
    tx_end_a: assert property (state_r == ST_TX && tx_done |=> irq_transmit_frame_end
        && !ack_active_r && state_r == ($past(transmit_then_receive_enable) ? ST_RX : ST_TRANSMIT_PREPARATION_STATE))
        else $error("Transmit end handling wrong");
    cca_busy_a: assert property (state_r == ST_ED && wait_done && ed_busy |=> irq_energy_detect_complete
        && irq_transmit_frame_end && cca_busy_result && state_r == ST_RX && !tx_start_r)
        else $error("Busy channel handling wrong");
    cca_clear_a: assert property (state_r == ST_ED && wait_done && !ed_busy |=> irq_transceiver_ready
        && !cca_busy_result && baseband_enable ##1 tx_start_r && state_r == ST_TX)
        else $error("Clear channel handling wrong");
    ed_start_a: assert property (ed_start && !receive_frame_end |=> state_r == ST_ED)
        else $error("Energy measurement not started");

    ack_done_c: cover property (state_r == ST_ACKWAIT ##[1:300] state_r == ST_TX ##[1:300] irq_transmit_frame_end);
    cca_busy_c: cover property (ed_start ##[1:1000] irq_transmit_frame_end && cca_busy_result);
    cca_clear_c: cover property (ed_start ##[1:1000] irq_transceiver_ready);
    tx2rx_c: cover property (state_r == ST_TX && tx_done && transmit_then_receive_enable);

endmodule : mac_auto_procedures

// file: verif/tx_partner.sv
// Transmitter stand-in that ends each frame after a set time on air
`timescale 1ns/1ns
module tx_partner (
    input wire logic core_clk, // Baseband clock
    input wire logic tx_start, // Transmit start pulse
    input wire logic [7:0] latency, // Cycles on air, at least 1
    output logic tx_done // Transmit finished pulse
);
    initial tx_done = 1'b0;
    always @(posedge core_clk) begin
        if (tx_start === 1'b1) begin
            repeat (latency) @(posedge core_clk);
            tx_done <= 1'b1;
            @(posedge core_clk);
            tx_done <= 1'b0;
        end
    end
endmodule : tx_partner

// file: verif/testbench.sv
// Self-checking bench for the MAC automation sequencer
`timescale 1ns/1ns
module testbench;
    import mac_auto_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic auto_acknowledge_enable, ack_rate_adapt_enable, ack_checksum_adapt_enable, ack_source_select;
    logic transmit_then_receive_enable, cca_transmit_enable, checksum_type_select, fsk_cfg_delimiter_select;
    logic oqpsk_cfg_legacy, oqpsk_cfg_ppdu_type, baseband_enable_write, baseband_enable_wdata;
    logic energy_detect_mode_write, host_tx_request, host_rx_request, receive_frame_end, rx_ack_request;
    logic rx_checksum_type, fsk_rx_delimiter_seen, oqpsk_rx_legacy, oqpsk_rx_ppdu_type, tx_done;
    logic [3:0] filter_unit_enable, ack_pending_flags, rx_unit_match;
    logic [7:0] ack_delay_low, ack_delay_high, tx_length_low, energy_threshold, energy_detect_duration;
    logic [7:0] rx_sequence_number, energy_level, latency;
    logic [2:0] tx_length_high, ofdm_cfg_coding_level, oqpsk_cfg_rate_mode, rx_frame_type;
    logic [2:0] ofdm_rx_coding_level, oqpsk_rx_rate_mode;
    logic [1:0] phy_mode, energy_detect_mode;
    radio_state_t radio_state;
    logic tx_start, tx_from_buffer, ack_frame_pending, checksum_type, fsk_tx_delimiter_select;
    logic oqpsk_tx_legacy, oqpsk_tx_ppdu_type, ed_active, cca_busy_result, baseband_enable;
    logic irq_energy_detect_complete, irq_transmit_frame_end, irq_transceiver_ready;
    logic [10:0] tx_length;
    logic [7:0] ack_sequence_number;
    logic [2:0] ofdm_tx_coding_level, oqpsk_tx_rate_mode;
    int n_errors = 0;
    int tests_run = 0;
    int n;

    mac_auto_procedures dut (.*);
    tx_partner partner (.core_clk(core_clk), .tx_start(tx_start), .latency(latency), .tx_done(tx_done));

    always #5 core_clk = ~core_clk;

    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("unexpected t=%0t %s", $time, msg);
        end
    endtask : check

    // One-cycle strobe: 0 frame end, 1 rx request, 2 tx request, 3 baseband write, 4 energy mode write
    task automatic hit(input int k);
        @(posedge core_clk);
        case (k)
            0: receive_frame_end <= 1'b1;
            1: host_rx_request <= 1'b1;
            2: host_tx_request <= 1'b1;
            3: baseband_enable_write <= 1'b1;
            default: energy_detect_mode_write <= 1'b1;
        endcase
        @(posedge core_clk);
        {receive_frame_end, host_rx_request, host_tx_request, baseband_enable_write, energy_detect_mode_write} <= '0;
    endtask : hit

    task automatic wait_hi(ref logic s, input int lim);
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (s !== 1'b1 && n < lim);
    endtask : wait_hi

    function automatic logic pend(input logic [3:0] m, input logic [3:0] f);
        for (int i = 0; i < 4; i++) if (m[i]) return f[i];
        return 1'b0;
    endfunction : pend

    task automatic ack_case(input logic [2:0] ft, input logic req, input logic bsrc, input logic fe);
        logic go;
        logic cs;
        go = fe && req && (ft == FRAME_TYPE_DATA || ft == FRAME_TYPE_CMD);
        @(posedge core_clk);
        filter_unit_enable <= fe ? 4'hF : 4'h0;
        ack_source_select <= bsrc;
        {rx_frame_type, rx_ack_request} <= {ft, req};
        {ack_delay_low, rx_unit_match} <= {8'($urandom_range(3)), 4'($urandom_range(15, 1))};
        {rx_sequence_number, ofdm_rx_coding_level, checksum_type_select} <= 12'($urandom);
        {ack_checksum_adapt_enable, rx_checksum_type, ack_pending_flags} <= 6'($urandom);
        phy_mode <= 2'($urandom_range(2));
        {ack_rate_adapt_enable, fsk_rx_delimiter_seen, oqpsk_rx_legacy} <= 3'($urandom);
        {oqpsk_rx_rate_mode, oqpsk_rx_ppdu_type} <= 4'($urandom);
        hit(0);
        cs = (ack_checksum_adapt_enable && (phy_mode == PHY_FSK || (phy_mode == PHY_OQPSK && oqpsk_rx_legacy)))
            ? rx_checksum_type : checksum_type_select;
        wait_hi(tx_start, 500);
        if (!go) begin
            check(tx_start !== 1'b1, "ack sent without cause");
            if (fe) check(radio_state === ST_TRANSMIT_PREPARATION_STATE, "no-ack frame not ending in prep");
        end else begin
            check(n === (int'({ack_delay_high, ack_delay_low}) + 1) * TICK_CYCLES, "ack delay");
            check(tx_from_buffer === bsrc, "ack source");
            check(tx_length === (bsrc ? {tx_length_high, tx_length_low}
                : (cs ? ACK_LEN_FCS16 : ACK_LEN_FCS32)), "ack length");
            if (!bsrc) check(ack_sequence_number === rx_sequence_number, "sequence copy");
            check(ack_frame_pending === pend(rx_unit_match, ack_pending_flags), "pending bit");
            check(ofdm_tx_coding_level === (ack_rate_adapt_enable && phy_mode == PHY_OFDM
                ? ofdm_rx_coding_level : ofdm_cfg_coding_level), "coding level adapt");
            check(fsk_tx_delimiter_select === (ack_rate_adapt_enable && phy_mode == PHY_FSK
                ? fsk_rx_delimiter_seen : fsk_cfg_delimiter_select), "delimiter adapt");
            check({oqpsk_tx_legacy, oqpsk_tx_rate_mode, oqpsk_tx_ppdu_type} === (ack_rate_adapt_enable
                && phy_mode == PHY_OQPSK ? {oqpsk_rx_legacy, oqpsk_rx_rate_mode, oqpsk_rx_ppdu_type}
                : {oqpsk_cfg_legacy, oqpsk_cfg_rate_mode, oqpsk_cfg_ppdu_type}), "o-qpsk adapt");
            check(checksum_type === cs, "checksum adapt");
            wait_hi(irq_transmit_frame_end, 60);
            check(n < 60, "no frame end after ack");
            @(posedge core_clk);
            #1;
            check(ofdm_tx_coding_level === ofdm_cfg_coding_level, "coding level restore");
            check({fsk_tx_delimiter_select, oqpsk_tx_legacy, oqpsk_tx_rate_mode, oqpsk_tx_ppdu_type, checksum_type}
                === {fsk_cfg_delimiter_select, oqpsk_cfg_legacy, oqpsk_cfg_rate_mode, oqpsk_cfg_ppdu_type,
                checksum_type_select}, "settings restore");
        end
        hit(1);
        @(posedge core_clk);
        $display("ack case type %0d req %0d src %0d filt %0d done", ft, req, bsrc, fe);
    endtask : ack_case

    task automatic cca_case(input logic [7:0] e);
        logic busy;
        busy = e > energy_threshold;
        energy_level <= e;
        baseband_enable_wdata <= 1'b0;
        hit(3);
        energy_detect_mode <= ED_MODE_SINGLE;
        hit(4);
        #1;
        check(ed_active === 1'b1, "measurement not running");
        wait_hi(irq_energy_detect_complete, 500);
        check(n === (int'(energy_detect_duration) + 1) * TICK_CYCLES, "measure time");
        check(ed_active === 1'b0, "measurement flag stuck");
        check(cca_busy_result === busy, "busy flag");
        check(irq_transmit_frame_end === busy, "busy frame end");
        check(irq_transceiver_ready === !busy, "ready pulse");
        check(baseband_enable === !busy, "baseband re-enable");
        if (!busy) begin
            wait_hi(irq_transmit_frame_end, 60);
            check(n < 60, "no frame end after clear");
            hit(1);
        end else begin
            check(radio_state === ST_RX, "busy not back in rx");
        end
        baseband_enable_wdata <= 1'b1;
        hit(3);
        $display("cca case energy %0d done", e);
    endtask : cca_case

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up

    initial begin
        #300000;
        n_errors++;
        wrap_up();
    end

    initial begin
        {auto_acknowledge_enable, ack_checksum_adapt_enable, ack_source_select, transmit_then_receive_enable,
            checksum_type_select, oqpsk_cfg_legacy, oqpsk_cfg_ppdu_type, baseband_enable_write, baseband_enable_wdata,
            energy_detect_mode_write, host_tx_request, host_rx_request, receive_frame_end, rx_ack_request,
            rx_checksum_type, fsk_rx_delimiter_seen, oqpsk_rx_legacy, oqpsk_rx_ppdu_type, ack_pending_flags,
            rx_unit_match, ack_delay_low, ack_delay_high, rx_sequence_number, energy_level, oqpsk_cfg_rate_mode,
            rx_frame_type, ofdm_rx_coding_level, oqpsk_rx_rate_mode, energy_detect_mode} = '0;
        {auto_acknowledge_enable, ack_rate_adapt_enable, cca_transmit_enable, fsk_cfg_delimiter_select} = 4'hF;
        {filter_unit_enable, latency, energy_threshold, energy_detect_duration} = {4'hF, 8'h10, 8'h80, 8'h01};
        {tx_length_high, tx_length_low, ofdm_cfg_coding_level, phy_mode} = {3'h1, 8'h2A, 3'h6, PHY_OFDM};
        void'($urandom(32'h2db93557));
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        #1;
        check(radio_state === ST_RX && baseband_enable === BASEBAND_RESET, "reset state");
        ack_case(FRAME_TYPE_DATA, 1'b1, 1'b0, 1'b1);
        ack_case(FRAME_TYPE_CMD, 1'b1, 1'b0, 1'b1);
        ack_case(FRAME_TYPE_DATA, 1'b1, 1'b1, 1'b1);
        ack_case(3'h0, 1'b1, 1'b0, 1'b1);
        ack_case(FRAME_TYPE_DATA, 1'b0, 1'b0, 1'b1);
        ack_case(FRAME_TYPE_DATA, 1'b1, 1'b0, 1'b0);
        for (int i = 0; i < 4; i++) ack_case(3'($urandom), 1'($urandom), 1'($urandom), 1'b1);
        cca_case(8'h81);
        cca_case(8'h80);
        cca_case(8'($urandom_range(127)));
        {auto_acknowledge_enable, cca_transmit_enable, transmit_then_receive_enable} <= 3'b001;
        hit(2);
        wait_hi(irq_transmit_frame_end, 60);
        check(n < 60 && radio_state === ST_RX, "transmit then receive");
        $display("transmit then receive case done");
        wrap_up();
    end
endmodule : testbench
